// ---- inc/adcce_cfg.svh ----
// Purpose: Offsets, field positions, reset values and counts of the channel enable bank
// Assumes: Byte addresses on an 8-bit register address, one 32-bit word per register
// Notes: Included by the package and by each design module, guarded against double inclusion
// Function
// R1: The read-only present mask has one bit per channel, 1 for present, and resets to 0x3ff.
// R2: The revision word at 0x34 holds a 12-bit revision in bits 11:0 and an inert variant field.
// R3: Writing ones to the enable set register at 0x40 enables those channels, zeros change nothing.
// R4: Writing ones to the enable clear register at 0x44 disables those channels, zeros change nothing.
// R5: The state register at 0x48 shows 1 per enabled channel and resets to all zeros.
// R6: Software avoids disabling or toggling a channel during a conversion, else its data is undefined.
// R7: The instance has ten conversion channels, eight external inputs and one temperature sensor.
// R8: Channels 0-2 and 4-8 select the external input of the same index, channel 9 the sensor.
// R9: All software-visible registers run on the single bus interface clock.
// R10: The conversion done flag sets when a conversion ends and its result is in the last result word; the code does so only for enabled channels.
// R11: Reads of the set and clear registers return zero, and writes to read-only registers are ignored.
`ifndef ADCCE_CFG_SVH
`define ADCCE_CFG_SVH
`define ADCCE_OFF_LAST_RESULT 8'h2c
`define ADCCE_OFF_PRESENT 8'h30
`define ADCCE_OFF_REVISION 8'h34
`define ADCCE_OFF_EN_SET 8'h40
`define ADCCE_OFF_EN_CLEAR 8'h44
`define ADCCE_OFF_EN_STATE 8'h48
`define ADCCE_OFF_IRQ_STATUS 8'h50
`define ADCCE_OFF_IRQ_CLEAR 8'h54
`define ADCCE_OFF_IRQ_ENABLE 8'h58
`define ADCCE_RST_PRESENT 32'h0000_03ff
`define ADCCE_RST_EN_STATE 32'h0000_0000
`define ADCCE_RST_IRQ 2'h0
`define ADCCE_RESULT_LSB 0
`define ADCCE_CHAN_LSB 16
`define ADCCE_VARIANT_LSB 16
`define ADCCE_EVT_DONE 0
`define ADCCE_EVT_OVERRUN 1
`define ADCCE_NUM_EVT 2
`define ADCCE_NUM_CH 10
`define ADCCE_ABSENT_INPUT 3
`define ADCCE_SENSOR_CH 9
`endif

// ---- inc/adcce_pkg.sv ----
// Purpose: Types and address decoding for the channel enable bank
// Assumes: adcce_cfg.svh carries every number
// Notes: Decode is shared by the read and write paths
`include "adcce_cfg.svh"
package adcce_pkg;
  typedef enum {
    ADCCE_REG_NONE,
    ADCCE_REG_LAST_RESULT,
    ADCCE_REG_PRESENT,
    ADCCE_REG_REVISION,
    ADCCE_REG_EN_SET,
    ADCCE_REG_EN_CLEAR,
    ADCCE_REG_EN_STATE,
    ADCCE_REG_IRQ_STATUS,
    ADCCE_REG_IRQ_CLEAR,
    ADCCE_REG_IRQ_ENABLE
  } adcce_reg_t;

  function automatic adcce_reg_t adcce_decode(input logic [7:0] addr);
    adcce_reg_t sel;
    sel = ADCCE_REG_NONE;
    case (addr)
      `ADCCE_OFF_LAST_RESULT: sel = ADCCE_REG_LAST_RESULT;
      `ADCCE_OFF_PRESENT: sel = ADCCE_REG_PRESENT;
      `ADCCE_OFF_REVISION: sel = ADCCE_REG_REVISION;
      `ADCCE_OFF_EN_SET: sel = ADCCE_REG_EN_SET;
      `ADCCE_OFF_EN_CLEAR: sel = ADCCE_REG_EN_CLEAR;
      `ADCCE_OFF_EN_STATE: sel = ADCCE_REG_EN_STATE;
      `ADCCE_OFF_IRQ_STATUS: sel = ADCCE_REG_IRQ_STATUS;
      `ADCCE_OFF_IRQ_CLEAR: sel = ADCCE_REG_IRQ_CLEAR;
      `ADCCE_OFF_IRQ_ENABLE: sel = ADCCE_REG_IRQ_ENABLE;
      default: sel = ADCCE_REG_NONE;
    endcase
    return sel;
  endfunction
endpackage

// ---- rtl/adcce_input_map.sv ----
// Purpose: Maps enabled channels onto analog input and sensor enables
// Assumes: Channel state arrives from the bank on the same clock
// Notes: Outputs are registered
`timescale 1ns/1ps
`include "adcce_cfg.svh"
module adcce_input_map
  import adcce_pkg::*;
#(
  parameter int NUM_CH = `ADCCE_NUM_CH
) (
  input wire logic core_clk,
  input wire logic rst_sync_n,
  input wire logic [NUM_CH-1:0] chan_enabled,
  output logic [NUM_CH-2:0] ext_input_en,
  output logic temp_sensor_en
);
  logic [NUM_CH-2:0] next_ext_input_en;

  // Same index mapping, absent input never driven
  genvar g;
  generate
    for (g = 0; g < NUM_CH - 1; g++) begin : g_map
      if (g == `ADCCE_ABSENT_INPUT) begin : g_absent
        assign next_ext_input_en[g] = 1'b0; // R8
      end else begin : g_present
        assign next_ext_input_en[g] = chan_enabled[g]; // R8
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ext_input_en <= '0;
      temp_sensor_en <= 1'b0;
    end else begin
      ext_input_en <= next_ext_input_en; // R7
      temp_sensor_en <= chan_enabled[`ADCCE_SENSOR_CH]; // R8
    end
  end
endmodule // adcce_input_map

// ---- rtl/adcce_regs.sv ----
// Purpose: Channel enable register bank of the converter interface
// Assumes: Plain register port, read data one cycle after the read strobe
// Notes: Converter event inputs come from logic on core_clk
`timescale 1ns/1ps
`include "adcce_cfg.svh"
module adcce_regs
  import adcce_pkg::*;
#(
  parameter int NUM_CH = `ADCCE_NUM_CH,
  parameter logic [11:0] REVISION = 12'h0a5,
  parameter logic [3:0] VARIANT = 4'h0
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic conv_done,
  input wire logic [4:0] conv_channel,
  input wire logic [11:0] conv_result,
  output logic [NUM_CH-1:0] chan_enabled,
  output logic [NUM_CH-2:0] ext_input_en,
  output logic temp_sensor_en,
  output logic irq
);
  // REVISION and VARIANT defaults are arbitrary values

  logic rst_meta_n;
  logic rst_sync_n;
  adcce_reg_t wr_sel;
  adcce_reg_t rd_sel;
  logic [NUM_CH-1:0] present_mask;
  logic [11:0] last_result;
  logic [4:0] last_channel;
  logic [`ADCCE_NUM_EVT-1:0] irq_status;
  logic [`ADCCE_NUM_EVT-1:0] irq_enable;
  logic [`ADCCE_NUM_EVT-1:0] evt;
  logic [`ADCCE_NUM_EVT-1:0] evt_clear;
  logic conv_accept;
  logic [31:0] next_rdata;
  logic [NUM_CH-1:0] next_chan_enabled;
  logic [NUM_CH-1:0] set_bits;
  logic [NUM_CH-1:0] clear_bits;

  // Reset release through two stages
  always_ff @(posedge core_clk or negedge rst_n) begin // R9
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  assign wr_sel = reg_wr ? adcce_decode(reg_addr) : ADCCE_REG_NONE;
  assign rd_sel = reg_rd ? adcce_decode(reg_addr) : ADCCE_REG_NONE;

  // Present mask, fixed after reset
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      present_mask <= NUM_CH'(`ADCCE_RST_PRESENT); // R1
    end else begin
      present_mask <= present_mask; // R11
    end
  end

  // Enable set only on present channels, clear on all channels
  assign set_bits = (wr_sel == ADCCE_REG_EN_SET) ? reg_wdata[NUM_CH-1:0] & present_mask : '0;
  assign clear_bits = (wr_sel == ADCCE_REG_EN_CLEAR) ? reg_wdata[NUM_CH-1:0] : '0;

  always_comb begin
    next_chan_enabled = (chan_enabled | set_bits) & ~clear_bits; // R3 R4
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      chan_enabled <= NUM_CH'(`ADCCE_RST_EN_STATE); // R5
    end else begin
      chan_enabled <= next_chan_enabled; // R3 R4
    end
  end

  // Conversion result capture, enabled channels only
  assign conv_accept = conv_done && (conv_channel < 5'(NUM_CH)) &&
                       chan_enabled[conv_channel[3:0]];

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      last_result <= 12'h000;
      last_channel <= 5'h00;
    end else if (conv_accept) begin
      last_result <= conv_result; // R10
      last_channel <= conv_channel;
    end
  end

  // Sticky events, set wins over clear
  assign evt[`ADCCE_EVT_DONE] = conv_accept; // R10
  assign evt[`ADCCE_EVT_OVERRUN] = conv_accept && irq_status[`ADCCE_EVT_DONE];
  assign evt_clear = (wr_sel == ADCCE_REG_IRQ_CLEAR) ?
                     reg_wdata[`ADCCE_NUM_EVT-1:0] : '0;

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq_status <= `ADCCE_RST_IRQ;
    end else begin
      irq_status <= (irq_status & ~evt_clear) | evt; // R10
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq_enable <= `ADCCE_RST_IRQ;
    end else if (wr_sel == ADCCE_REG_IRQ_ENABLE) begin
      irq_enable <= reg_wdata[`ADCCE_NUM_EVT-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((irq_status & ~evt_clear) | evt) & irq_enable);
    end
  end

  // Read mux
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (rd_sel)
      ADCCE_REG_LAST_RESULT: begin
        next_rdata[`ADCCE_RESULT_LSB +: 12] = last_result;
        next_rdata[`ADCCE_CHAN_LSB +: 5] = last_channel;
      end
      ADCCE_REG_PRESENT: next_rdata[NUM_CH-1:0] = present_mask; // R1
      ADCCE_REG_REVISION: begin
        next_rdata[11:0] = REVISION; // R2
        next_rdata[`ADCCE_VARIANT_LSB +: 4] = VARIANT; // R2
      end
      ADCCE_REG_EN_STATE: next_rdata[NUM_CH-1:0] = chan_enabled; // R5
      ADCCE_REG_IRQ_STATUS: next_rdata[`ADCCE_NUM_EVT-1:0] = irq_status;
      ADCCE_REG_IRQ_ENABLE: next_rdata[`ADCCE_NUM_EVT-1:0] = irq_enable;
      ADCCE_REG_EN_SET: next_rdata = 32'h0000_0000; // R11
      ADCCE_REG_EN_CLEAR: next_rdata = 32'h0000_0000; // R11
      ADCCE_REG_IRQ_CLEAR: next_rdata = 32'h0000_0000;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  adcce_input_map #(
    .NUM_CH(NUM_CH)
  ) u_input_map (
    .core_clk(core_clk),
    .rst_sync_n(rst_sync_n),
    .chan_enabled(chan_enabled),
    .ext_input_en(ext_input_en),
    .temp_sensor_en(temp_sensor_en)
  );

  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_sync_n);

  present_fixed_a: assert property ( // R1
    present_mask == NUM_CH'(`ADCCE_RST_PRESENT))
    else $error("present mask changed");

  revision_read_a: assert property ( // R2
    rd_sel == ADCCE_REG_REVISION |=> reg_rdata[11:0] == REVISION && reg_rdata[31:20] == 12'h000)
    else $error("revision word wrong");

  set_enables_a: assert property ( // R3
    wr_sel == ADCCE_REG_EN_SET |=> (chan_enabled & $past(set_bits)) == $past(set_bits))
    else $error("set write did not enable");

  set_zero_keep_a: assert property ( // R3
    wr_sel == ADCCE_REG_EN_SET |=> chan_enabled == ($past(chan_enabled) | $past(set_bits)))
    else $error("set write touched other channels");

  clear_disables_a: assert property ( // R4
    wr_sel == ADCCE_REG_EN_CLEAR |=> (chan_enabled & $past(clear_bits)) == '0)
    else $error("clear write did not disable");

  clear_zero_keep_a: assert property ( // R4
    wr_sel == ADCCE_REG_EN_CLEAR |=> chan_enabled == ($past(chan_enabled) & ~$past(clear_bits)))
    else $error("clear write touched other channels");

  state_read_a: assert property ( // R5
    rd_sel == ADCCE_REG_EN_STATE |=> reg_rdata[NUM_CH-1:0] == $past(chan_enabled))
    else $error("state read mismatch");

  state_hold_a: assert property ( // R5
    wr_sel != ADCCE_REG_EN_SET && wr_sel != ADCCE_REG_EN_CLEAR |=> $stable(chan_enabled))
    else $error("enable state changed without write");

  sensor_map_a: assert property ( // R8
    ##1 temp_sensor_en == $past(chan_enabled[`ADCCE_SENSOR_CH]))
    else $error("sensor enable not following channel");

  absent_input_a: assert property ( // R8
    ext_input_en[`ADCCE_ABSENT_INPUT] == 1'b0)
    else $error("absent input driven");

  input_follow_a: assert property ( // R7
    ##1 ext_input_en[0] == $past(chan_enabled[0]) && ext_input_en[8] == $past(chan_enabled[8]))
    else $error("input enable lag wrong");

  done_flag_a: assert property ( // R10
    conv_accept |=> irq_status[`ADCCE_EVT_DONE] && last_result == $past(conv_result))
    else $error("done flag or result not captured");

  set_wins_a: assert property ( // R10
    conv_accept && evt_clear[`ADCCE_EVT_DONE] |=> irq_status[`ADCCE_EVT_DONE])
    else $error("clear beat a new event");

  wo_reads_zero_a: assert property ( // R11
    rd_sel == ADCCE_REG_EN_SET || rd_sel == ADCCE_REG_EN_CLEAR |=> reg_rdata == 32'h0000_0000)
    else $error("write-only register read nonzero");

  ro_write_ignored_a: assert property ( // R11
    wr_sel == ADCCE_REG_EN_STATE || wr_sel == ADCCE_REG_PRESENT |=> $stable(chan_enabled))
    else $error("read-only write had effect");

  irq_level_a: assert property (
    ##1 irq == |(irq_status & $past(irq_enable)))
    else $error("interrupt level wrong");

  enable_cov_c: cover property (wr_sel == ADCCE_REG_EN_SET ##1 chan_enabled != '0);
  disable_cov_c: cover property (wr_sel == ADCCE_REG_EN_CLEAR && chan_enabled != '0);
  done_cov_c: cover property (conv_accept ##1 irq);
  overrun_cov_c: cover property (evt[`ADCCE_EVT_OVERRUN]);
endmodule // adcce_regs

// ---- verification/adcce_regs_test.sv ----
// Purpose: Self-checking bench of the channel enable register bank
// Assumes: Register port with read data one cycle after the read strobe
// Notes: Interrupt, mapping and reset behaviour are covered through port sequences
`timescale 1ns/1ps
module adcce_regs_test;
  import adcce_pkg::*;
  localparam logic [11:0] REV = 12'h0a5;
  localparam logic [3:0] VAR = 4'h0;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic conv_done = 1'b0;
  logic [4:0] conv_channel = 5'h00;
  logic [11:0] conv_result = 12'h000;
  logic [9:0] chan_enabled;
  logic [8:0] ext_input_en;
  logic temp_sensor_en;
  logic irq;
  int n_errors = 0;
  int num_checks = 0;
  int cycles = 0;

  adcce_regs #(.NUM_CH(10), .REVISION(REV), .VARIANT(VAR)) i_adcce_regs (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_done(conv_done),
    .conv_channel(conv_channel), .conv_result(conv_result), .chan_enabled(chan_enabled),
    .ext_input_en(ext_input_en), .temp_sensor_en(temp_sensor_en), .irq(irq)
  );

  initial begin
    forever #2 core_clk = ~core_clk;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors = n_errors + 1;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("Error at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  task automatic conv(input logic [4:0] ch, input logic [11:0] res);
    @(posedge core_clk);
    conv_done <= 1'b1;
    conv_channel <= ch;
    conv_result <= res;
    @(posedge core_clk);
    conv_done <= 1'b0;
    @(posedge core_clk);
    #1;
  endtask

  task automatic do_reset(input int n);
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (n) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask

  initial begin
    do_reset(8);
    rd(8'h30, 32'h0000_03ff);
    rd(8'h34, {12'h000, VAR, 4'h0, REV});
    rd(8'h48, 32'h0000_0000);
    chk({22'h0, chan_enabled}, 32'h0000_0000);
    $display("test reset values done");
    wr(8'h40, 32'h0000_0205);
    rd(8'h48, 32'h0000_0205);
    wr(8'h40, 32'h0000_0010);
    rd(8'h48, 32'h0000_0215);
    wr(8'h44, 32'h0000_0004);
    rd(8'h48, 32'h0000_0211);
    wr(8'h44, 32'h0000_0000);
    wr(8'h40, 32'hffff_fc00);
    rd(8'h48, 32'h0000_0211);
    $display("test set and clear done");
    wr(8'h40, 32'h0000_03ff);
    rd(8'h48, 32'h0000_03ff);
    chk({23'h0, ext_input_en}, 32'h0000_01f7);
    chk({31'h0, temp_sensor_en}, 32'h0000_0001);
    wr(8'h44, 32'h0000_0208);
    @(posedge core_clk);
    #1;
    chk({23'h0, ext_input_en}, 32'h0000_01f7);
    chk({31'h0, temp_sensor_en}, 32'h0000_0000);
    $display("test input map done");
    rd(8'h40, 32'h0000_0000);
    rd(8'h44, 32'h0000_0000);
    rd(8'h54, 32'h0000_0000);
    wr(8'h48, 32'h0000_0000);
    wr(8'h30, 32'h0000_0000);
    wr(8'h34, 32'hffff_ffff);
    rd(8'h48, 32'h0000_01f7);
    rd(8'h30, 32'h0000_03ff);
    rd(8'h34, {12'h000, VAR, 4'h0, REV});
    rd(8'hfc, 32'h0000_0000);
    $display("test read only and write only done");
    wr(8'h58, 32'h0000_0001);
    rd(8'h58, 32'h0000_0001);
    conv(5'd3, 12'h123);
    rd(8'h50, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    conv(5'd0, 12'habc);
    chk({31'h0, irq}, 32'h0000_0001);
    rd(8'h2c, 32'h0000_0abc);
    rd(8'h50, 32'h0000_0001);
    conv(5'd8, 12'h5a5);
    rd(8'h2c, 32'h0008_05a5);
    rd(8'h50, 32'h0000_0003);
    wr(8'h54, 32'h0000_0003);
    rd(8'h50, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(8'h58, 32'h0000_0000);
    conv(5'd1, 12'h0f0);
    rd(8'h50, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(8'h58, 32'h0000_0001);
    rd(8'h50, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(8'h54, 32'h0000_0001);
    rd(8'h50, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    // Conversion end and status clear in one cycle
    @(posedge core_clk);
    conv_done <= 1'b1;
    conv_channel <= 5'd0;
    conv_result <= 12'h321;
    reg_wr <= 1'b1;
    reg_addr <= 8'h54;
    reg_wdata <= 32'h0000_0001;
    @(posedge core_clk);
    conv_done <= 1'b0;
    reg_wr <= 1'b0;
    rd(8'h50, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0001);
    rd(8'h2c, 32'h0000_0321);
    wr(8'h54, 32'h0000_0001);
    $display("test interrupts done");
    do_reset(2);
    rd(8'h48, 32'h0000_0000);
    rd(8'h58, 32'h0000_0000);
    rd(8'h30, 32'h0000_03ff);
    chk({31'h0, temp_sensor_en}, 32'h0000_0000);
    $display("test second reset done");
    conclude();
  end
endmodule // adcce_regs_test
